// ===== hw/ufcb_consts.svh
// Offsets, field positions, reset values and thresholds of the flow-control and bypass block
`ifndef UFCB_CONSTS_SVH
`define UFCB_CONSTS_SVH

// Subsystem memory-space addresses
`define UFCB_SS_CTRL       9'h110
`define UFCB_SS_MCR_WR     9'h130
`define UFCB_SS_FCR_RD     9'h132
`define UFCB_SS_MCR_RD     9'h134
`define UFCB_SS_BYPASS     9'h140

// Host I/O addresses
`define UFCB_H_DATA        3'h0
`define UFCB_H_FCR         3'h2
`define UFCB_H_MCR         3'h4
`define UFCB_H_STAT        3'h5

// Field positions
`define UFCB_CTRL_BYPASS   7
`define UFCB_CTRL_IRQCLR   6
`define UFCB_MCR_AUTOCTS   5
`define UFCB_MCR_RTS       1
`define UFCB_FCR_RXRST     1
`define UFCB_FCR_TXRST     2
`define UFCB_FCR_AUTORTS   4
`define UFCB_FCR_DEEP      5
`define UFCB_FCR_TRIG_HI   7
`define UFCB_FCR_TRIG_LO   6

// Reset values
`define UFCB_CTRL_RST      8'h22
`define UFCB_FCR_RST       8'h00
`define UFCB_MCR_RST       5'h00

// FIFO depths and fill levels
`define UFCB_DEPTH_SHORT   7'h10
`define UFCB_DEPTH_DEEP    7'h40
`define UFCB_RTS_SHORT     7'h0E
`define UFCB_RTS_DEEP      7'h38
`define UFCB_TRIG_S0       7'h01
`define UFCB_TRIG_S1       7'h04
`define UFCB_TRIG_S2       7'h08
`define UFCB_TRIG_S3       7'h0E
`define UFCB_TRIG_D0       7'h01
`define UFCB_TRIG_D1       7'h10
`define UFCB_TRIG_D2       7'h20
`define UFCB_TRIG_D3       7'h38

`endif

// ===== hw/ufcb_pkg.sv
// Types shared by the flow-control and bypass block
package ufcb_pkg;
  typedef logic [7:0] ufcb_byte_t;
  typedef logic [8:0] ufcb_ss_addr_t;
  typedef logic [2:0] ufcb_host_addr_t;
  typedef logic [6:0] ufcb_count_t;
endpackage

// ===== hw/ufcb_fifo_if.sv
// Write and read sides of one FIFO, with its fill count and flush
interface ufcb_fifo_if #(
  parameter int WIDTH = 8,
  parameter int CW    = 7
);
  logic             wrValid;
  logic             wrReady;
  logic [WIDTH-1:0] wrData;
  logic             rdValid;
  logic             rdReady;
  logic [WIDTH-1:0] rdData;
  logic [CW-1:0]    count;
  logic             flush;

  modport fifo (
    input  wrValid, wrData, rdReady, flush,
    output wrReady, rdValid, rdData, count
  );
  modport user (
    output wrValid, wrData, rdReady, flush,
    input  wrReady, rdValid, rdData, count
  );
endinterface

// ===== hw/ufcb_fifo.sv
// Synchronous FIFO with parameterised width and depth
module ufcb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic  clk_sys,
  input wire logic  rst,
  // Both sides of the buffer
  ufcb_fifo_if.fifo fp
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [CW-1:0]    count;
  wire              doWr = fp.wrValid && fp.wrReady;
  wire              doRd = fp.rdReady && fp.rdValid;

  assign fp.wrReady = (count != CW'(DEPTH));
  assign fp.rdValid = (count != '0);
  assign fp.rdData  = mem[rdPtr];
  assign fp.count   = count;

  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr] <= fp.wrData;
    end
  end

  // Flush drops everything, including a write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst || fp.flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= AW'(wrPtr + 1'b1);
      end
      if (doRd) begin
        rdPtr <= AW'(rdPtr + 1'b1);
      end
      count <= CW'(count + CW'(doWr) - CW'(doRd));
    end
  end
endmodule

// ===== hw/ufcb_top.sv
// Serial bypass, auto-CTS and auto-RTS around the receiver and transmitter FIFOs
// How it works
// - Bypass bit set: subsystem writes at bypass port fill RX FIFO, reads drain TX FIFO.
// - In bypass, host interrupts continue, but no parity, framing or break events.
// - Auto-CTS: CTS high lets current character finish, then transmitter waits for low.
// - Auto-CTS never alters interrupt generation, priority or clearing.
// - Auto-RTS only with FIFO-control bit 4 high, extend low; independent of trigger.
// - Short FIFO with auto-RTS: 14 received characters clear RTS bit, RTS pin high.
// - Deep FIFO with auto-RTS: 56 received characters clear the RTS bit.
// - Interrupts unchanged by auto-RTS; data-available still fires at trigger level.
// - Extend low: FIFO-control bit 5 picks 64 or 16 bytes; extend high: 16, no auto-RTS.
// - Deep mode trigger select 00,01,10,11 gives levels 1, 16, 32, 56.
// - Reset clears the bypass bit in the subsystem control register.
`include "ufcb_consts.svh"

module ufcb_top #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // Pins
  input  wire logic                     extendPin,
  input  wire logic                     ctsN,
  output logic                          rtsN,
  // Subsystem memory port
  input  wire ufcb_pkg::ufcb_ss_addr_t  ssAddr,
  input  wire logic                     ssWr,
  input  wire logic                     ssRd,
  input  wire ufcb_pkg::ufcb_byte_t     ssWrData,
  output ufcb_pkg::ufcb_byte_t          ssRdData,
  // Host I/O port
  input  wire ufcb_pkg::ufcb_host_addr_t hostAddr,
  input  wire logic                     hostWr,
  input  wire logic                     hostRd,
  input  wire ufcb_pkg::ufcb_byte_t     hostWrData,
  output ufcb_pkg::ufcb_byte_t          hostRdData,
  // Serial engine
  output ufcb_pkg::ufcb_byte_t          serTxData,
  output logic                          serTxValid,
  input  wire logic                     serTxTake,
  input  wire ufcb_pkg::ufcb_byte_t     serRxData,
  input  wire logic                     serRxValid,
  input  wire logic                     serRxParityErr,
  input  wire logic                     serRxFrameErr,
  input  wire logic                     serRxBreak,
  // Interrupt sources to the core
  output logic                          rxDataAvail,
  output logic                          txEmpty,
  output logic                          lineErr,
  output logic                          bypassActive
);
  import ufcb_pkg::*;

  ufcb_fifo_if #(.WIDTH(8), .CW(7)) rxIf ();
  ufcb_fifo_if #(.WIDTH(8), .CW(7)) txIf ();

  ufcb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fp      (rxIf.fifo)
  );
  ufcb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fp      (txIf.fifo)
  );

  function automatic ufcb_count_t trigLevel(input logic deepMode, input logic [1:0] sel);
    ufcb_count_t lvl;
    lvl = `UFCB_TRIG_S0;
    unique case ({deepMode, sel})
      3'h0: lvl = `UFCB_TRIG_S0;
      3'h1: lvl = `UFCB_TRIG_S1;
      3'h2: lvl = `UFCB_TRIG_S2;
      3'h3: lvl = `UFCB_TRIG_S3;
      3'h4: lvl = `UFCB_TRIG_D0;
      3'h5: lvl = `UFCB_TRIG_D1;
      3'h6: lvl = `UFCB_TRIG_D2;
      3'h7: lvl = `UFCB_TRIG_D3;
    endcase
    return lvl;
  endfunction

  // Pin synchronisers; CTS resets inactive so nothing is sent before it is seen
  logic extendMeta;
  logic extendSync;
  logic ctsMeta;
  logic ctsSync;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      extendMeta <= 1'b0;
      extendSync <= 1'b0;
      ctsMeta    <= 1'b1;
      ctsSync    <= 1'b1;
    end else begin
      extendMeta <= extendPin;
      extendSync <= extendMeta;
      ctsMeta    <= ctsN;
      ctsSync    <= ctsMeta;
    end
  end

  // Control state
  ufcb_byte_t ctrl;
  ufcb_byte_t fifo_control_reg;
  logic [4:0] subsystem_modem_control_view;
  logic       autoCts;
  logic       holdFull;

  // Address decode
  wire ssCtrlWr  = ssWr && (ssAddr == `UFCB_SS_CTRL);
  wire ssMcrWr   = ssWr && (ssAddr == `UFCB_SS_MCR_WR);
  wire bypassOn  = ctrl[`UFCB_CTRL_BYPASS];
  wire bypassWr  = ssWr && (ssAddr == `UFCB_SS_BYPASS) && bypassOn;
  wire bypassRd  = ssRd && (ssAddr == `UFCB_SS_BYPASS) && bypassOn;
  wire hostDatWr = hostWr && (hostAddr == `UFCB_H_DATA);
  wire hostDatRd = hostRd && (hostAddr == `UFCB_H_DATA);
  wire hostFcrWr = hostWr && (hostAddr == `UFCB_H_FCR);
  wire hostMcrWr = hostWr && (hostAddr == `UFCB_H_MCR);

  // FIFO mode selection
  wire         deepMode = fifo_control_reg[`UFCB_FCR_DEEP] && !extendSync;
  wire         autoRts  = fifo_control_reg[`UFCB_FCR_AUTORTS] && !extendSync;
  wire [6:0]   fifoLim  = deepMode ? `UFCB_DEPTH_DEEP : `UFCB_DEPTH_SHORT;
  wire [6:0]   rtsLevel = deepMode ? `UFCB_RTS_DEEP : `UFCB_RTS_SHORT;
  wire [6:0]   rxTrig   = trigLevel(deepMode,
                                    {fifo_control_reg[`UFCB_FCR_TRIG_HI], fifo_control_reg[`UFCB_FCR_TRIG_LO]});
  wire         rtsHit   = autoRts && (rxIf.count >= rtsLevel);

  // Receive path: bypass writes replace the serial receiver
  wire         serRxUse = serRxValid && !bypassOn;
  wire         rxWant   = bypassWr || serRxUse;
  wire         rxRoom   = (rxIf.count < fifoLim) && rxIf.wrReady;
  wire         rxDrop   = rxWant && !rxRoom;
  wire         serRxErr = serRxUse && (serRxParityErr || serRxFrameErr || serRxBreak);

  assign rxIf.wrValid = rxWant && rxRoom;
  assign rxIf.wrData  = bypassWr ? ssWrData : serRxData;
  assign rxIf.rdReady = hostDatRd;
  assign rxIf.flush   = hostFcrWr && hostWrData[`UFCB_FCR_RXRST];

  // Transmit path: bypass reads replace the serial transmitter
  wire         txRoom    = (txIf.count < fifoLim) && txIf.wrReady;
  wire         txTaken   = serTxValid && serTxTake;
  wire         txLoad    = !bypassOn && !holdFull && txIf.rdValid;
  wire         ctsBlock  = autoCts && ctsSync;
  wire         next_holdFull = (holdFull && !txTaken) || txLoad;

  assign txIf.wrValid = hostDatWr && txRoom;
  assign txIf.wrData  = hostWrData;
  assign txIf.rdReady = bypassRd || txLoad;
  assign txIf.flush   = hostFcrWr && hostWrData[`UFCB_FCR_TXRST];

  // Register views
  wire ufcb_byte_t mcrView = {2'b00, autoCts, subsystem_modem_control_view};
  wire ufcb_byte_t fcrView = {fifo_control_reg[`UFCB_FCR_TRIG_HI:`UFCB_FCR_TRIG_LO],
                              !(fifo_control_reg[`UFCB_FCR_DEEP] && !extendSync),
                              !(fifo_control_reg[`UFCB_FCR_AUTORTS] && !extendSync),
                              1'b0, 2'b11, fifo_control_reg[0]};
  wire ufcb_byte_t ctrlView = {ctrl[7], 1'b0, ctrl[5:0]};
  wire ufcb_byte_t bypassView = txIf.rdValid ? txIf.rdData : 8'h00;
  wire         txIdle   = !txIf.rdValid && !holdFull;
  wire ufcb_byte_t statView = {1'b0, txIdle, txIdle, 4'h0, rxIf.rdValid};

  wire ufcb_byte_t next_ssRdData =
    !ssRd                          ? ssRdData :
    (ssAddr == `UFCB_SS_CTRL)      ? ctrlView :
    (ssAddr == `UFCB_SS_FCR_RD)    ? fcrView :
    (ssAddr == `UFCB_SS_MCR_RD)    ? mcrView :
    bypassRd                       ? bypassView : 8'h00;
  wire ufcb_byte_t next_hostRdData =
    !hostRd                        ? hostRdData :
    hostDatRd                      ? (rxIf.rdValid ? rxIf.rdData : 8'h00) :
    (hostAddr == `UFCB_H_MCR)      ? mcrView :
    (hostAddr == `UFCB_H_STAT)     ? statView : 8'h00;

  // Subsystem-owned bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl    <= `UFCB_CTRL_RST;
      autoCts <= 1'b0;
    end else begin
      if (ssCtrlWr) begin
        ctrl <= ssWrData;
      end
      if (ssMcrWr) begin
        autoCts <= ssWrData[`UFCB_MCR_AUTOCTS];
      end
    end
  end

  // Host-owned bits; a host write of RTS in the same cycle beats the automatic clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fifo_control_reg <= `UFCB_FCR_RST;
      subsystem_modem_control_view <= `UFCB_MCR_RST;
    end else begin
      if (hostFcrWr) begin
        fifo_control_reg <= hostWrData;
      end
      if (hostMcrWr) begin
        subsystem_modem_control_view <= hostWrData[4:0];
      end else if (rtsHit) begin
        subsystem_modem_control_view[`UFCB_MCR_RTS] <= 1'b0;
      end
    end
  end

  // Transmit holding stage: a withheld character has not started, so it is safe to pull back
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdFull   <= 1'b0;
      serTxValid <= 1'b0;
      serTxData  <= 8'h00;
    end else begin
      holdFull   <= next_holdFull;
      serTxValid <= next_holdFull && !ctsBlock && !bypassOn;
      if (txLoad) begin
        serTxData <= txIf.rdData;
      end
    end
  end

  // Outputs; interrupt sources ignore both automatic flow-control modes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rtsN         <= 1'b1;
      ssRdData     <= 8'h00;
      hostRdData   <= 8'h00;
      rxDataAvail  <= 1'b0;
      txEmpty      <= 1'b1;
      lineErr      <= 1'b0;
      bypassActive <= 1'b0;
    end else begin
      rtsN         <= !subsystem_modem_control_view[`UFCB_MCR_RTS];
      ssRdData     <= next_ssRdData;
      hostRdData   <= next_hostRdData;
      rxDataAvail  <= (rxIf.count >= rxTrig);
      txEmpty      <= txIdle;
      lineErr      <= serRxErr || rxDrop;
      bypassActive <= bypassOn;
    end
  end
endmodule

// ===== sim/ufcb_checker.sv
// Port-level assertions for the flow-control and bypass block
`include "ufcb_consts.svh"

module ufcb_checker #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // Pins
  input wire logic                      extendPin,
  input wire logic                      ctsN,
  input wire logic                      rtsN,
  // Register ports
  input wire ufcb_pkg::ufcb_ss_addr_t   ssAddr,
  input wire logic                      ssWr,
  input wire ufcb_pkg::ufcb_byte_t      ssWrData,
  input wire ufcb_pkg::ufcb_host_addr_t hostAddr,
  input wire logic                      hostWr,
  input wire ufcb_pkg::ufcb_byte_t      hostWrData,
  // Serial engine and status
  input wire logic                      serTxValid,
  input wire logic                      serTxTake,
  input wire logic                      serRxValid,
  input wire logic                      lineErr,
  input wire logic                      bypassActive
);
  import ufcb_pkg::*;
  wire  hostMcrWr = hostWr && hostAddr == `UFCB_H_MCR;
  logic autoCts;

  // Shadow of the subsystem auto-CTS enable, which is not visible at the ports
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      autoCts <= 1'b0;
    end else if (ssWr && ssAddr == `UFCB_SS_MCR_WR) begin
      autoCts <= ssWrData[5];
    end
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ctrl_bypass_a: assert property (ssWr && ssAddr == `UFCB_SS_CTRL && ssWrData[7]
    |=> ##1 bypassActive) else $error("Bypass enable write not seen");
  rst_clear_a: assert property ($fell(rst)
    |-> !bypassActive && rtsN && !serTxValid) else $error("Bad state after reset");
  take_drop_a: assert property (serTxValid && serTxTake
    |=> !serTxValid) else $error("Offer stays after take");
  cts_hold_a: assert property ((autoCts && ctsN)[*5]
    |-> !serTxValid) else $error("Offer while clear-to-send inactive");
  byp_idle_a: assert property (bypassActive[*3]
    |-> !serTxValid) else $error("Serial offer during bypass");
  byp_rxerr_a: assert property (bypassActive[*3] ##0 (serRxValid && !ssWr)
    |=> !lineErr) else $error("Serial receive event during bypass");
  rts_drop_a: assert property (hostMcrWr && !hostWrData[1]
    |=> ##1 rtsN) else $error("Ready-to-send not driven high");
  rts_ext_a: assert property (extendPin[*4] ##0 (hostMcrWr && hostWrData[1]) ##1 !hostMcrWr
    |=> !rtsN) else $error("Ready-to-send not driven low");
  ext_noauto_a: assert property ((extendPin && !hostMcrWr)[*6]
    |-> !$rose(rtsN)) else $error("Automatic ready-to-send with extend high");
endmodule

bind ufcb_top ufcb_checker #(.DEPTH(DEPTH)) chk (
  .clk_sys, .rst, .extendPin, .ctsN, .rtsN, .ssAddr, .ssWr, .ssWrData, .hostAddr, .hostWr,
  .hostWrData, .serTxValid, .serTxTake, .serRxValid, .lineErr, .bypassActive
);

// ===== sim/ufcb_ser_model.sv
// Behavioural serial engine: takes offered characters and delivers received ones
module ufcb_ser_model (
  // Clock
  input wire logic                 clk_sys,
  // Transmit handshake
  input wire ufcb_pkg::ufcb_byte_t serTxData,
  input wire logic                 serTxValid,
  output logic                     serTxTake,
  // Receive strobe and qualifiers
  output ufcb_pkg::ufcb_byte_t     serRxData,
  output logic                     serRxValid,
  output logic                     serRxParityErr,
  output logic                     serRxFrameErr,
  output logic                     serRxBreak
);
  timeunit 1ns;
  timeprecision 1ps;
  import ufcb_pkg::*;
  int         stall = 0;
  int         waitN = 0;
  ufcb_byte_t txSeen[$];

  initial begin
    serTxTake = 1'b0;
    serRxValid = 1'b0;
    serRxData = 8'h00;
    {serRxParityErr, serRxFrameErr, serRxBreak} = 3'h0;
  end

  // Takes only an offered character, after a stall the bench may lengthen
  always @(negedge clk_sys) begin
    serTxTake <= serTxValid && !serTxTake && waitN >= stall;
    waitN <= (serTxValid && waitN < stall) ? waitN + 1 : 0;
  end

  always @(posedge clk_sys) begin
    if (serTxValid && serTxTake) begin
      txSeen.push_back(serTxData);
    end
  end

  // Lines go to inverse values after the strobe so stale data never matches
  task automatic sendRx(input ufcb_byte_t dat, input logic [2:0] err);
    @(negedge clk_sys);
    serRxData = dat;
    {serRxParityErr, serRxFrameErr, serRxBreak} = err;
    serRxValid = 1'b1;
    @(negedge clk_sys);
    serRxValid = 1'b0;
    serRxData = ~dat;
    {serRxParityErr, serRxFrameErr, serRxBreak} = ~err;
  endtask
endmodule

// ===== sim/test_uart_flow_control_bypass.sv
// Self-checking bench for the flow-control and bypass block
`include "ufcb_consts.svh"

module test_uart_flow_control_bypass;
  timeunit 1ns;
  timeprecision 1ps;
  import ufcb_pkg::*;
  logic            clk_sys, rst, extendPin, ctsN, ssWr, ssRd, hostWr, hostRd, rtsN;
  logic            serTxValid, serTxTake, serRxValid, serRxParityErr, serRxFrameErr;
  logic            serRxBreak, rxDataAvail, txEmpty, lineErr, bypassActive;
  ufcb_ss_addr_t   ssAddr;
  ufcb_host_addr_t hostAddr;
  ufcb_byte_t      ssWrData, ssRdData, hostWrData, hostRdData, serTxData, serRxData;
  ufcb_byte_t      rdVal, d, fifo_control_reg;
  logic [8:0]      modes [8] = '{9'h010, 9'h050, 9'h0A0, 9'h030, 9'h070, 9'h0B0, 9'h0E0, 9'h1F0};
  int              sLvl [4] = '{1, 4, 8, 14};
  int              dLvl [4] = '{1, 16, 32, 56};
  int              num_errors = 0;
  int              samples_checked = 0;
  int              seed, lvl, thr, lim, k, rxQ[$], txQ[$];
  bit              deep, autoR;

  ufcb_top #(.DEPTH(64)) uut (
    .clk_sys, .rst, .extendPin, .ctsN, .rtsN, .ssAddr, .ssWr, .ssRd, .ssWrData, .ssRdData,
    .hostAddr, .hostWr, .hostRd, .hostWrData, .hostRdData, .serTxData, .serTxValid,
    .serTxTake, .serRxData, .serRxValid, .serRxParityErr, .serRxFrameErr, .serRxBreak,
    .rxDataAvail, .txEmpty, .lineErr, .bypassActive
  );
  ufcb_ser_model uSer (
    .clk_sys, .serTxData, .serTxValid, .serTxTake, .serRxData, .serRxValid,
    .serRxParityErr, .serRxFrameErr, .serRxBreak
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle strobe on either port; read data is taken once the edge has landed
  task automatic acc(input bit host, input bit wr, input logic [8:0] a, input ufcb_byte_t dat);
    @(negedge clk_sys);
    {ssAddr, hostAddr, ssWrData, hostWrData} = {a, a[2:0], dat, dat};
    {hostWr, hostRd, ssWr, ssRd} = {host & wr, host & !wr, !host & wr, !host & !wr};
    @(negedge clk_sys);
    {hostWr, hostRd, ssWr, ssRd} = 4'h0;
    rdVal = host ? hostRdData : ssRdData;
  endtask

  task automatic pushTx(input int n);
    repeat (n) begin
      d = $random(seed);
      txQ.push_back(d);
      acc(1, 1, `UFCB_H_DATA, d);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  initial begin
    seed = 32'h60F10978;
    {rst, extendPin, ctsN, ssWr, ssRd, hostWr, hostRd} = 7'h40;
    {ssAddr, hostAddr, ssWrData, hostWrData} = '0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    check(bypassActive, 1'b0);
    acc(0, 0, `UFCB_SS_CTRL, 8'h00);
    check(rdVal, `UFCB_CTRL_RST);
    // Normal mode: an errored serial character is flagged and still stored
    d = $random(seed);
    uSer.sendRx(d, 3'h1);
    check(lineErr, 1'b1);
    acc(1, 0, `UFCB_H_DATA, 8'h00);
    check(rdVal, d);
    // Auto-CTS holds characters back until clear-to-send returns low
    ctsN = 1'b1;
    uSer.stall = 3;
    acc(0, 1, `UFCB_SS_MCR_WR, 8'h20);
    acc(0, 0, `UFCB_SS_MCR_RD, 8'h00);
    check(rdVal, 8'h20);
    pushTx(3);
    repeat (10) @(negedge clk_sys);
    check(uSer.txSeen.size(), 8'h00);
    ctsN = 1'b0;
    for (k = 0; k < 200 && uSer.txSeen.size() < 3; k++) @(negedge clk_sys);
    while (txQ.size() > 0) check(uSer.txSeen.pop_front(), 8'(txQ.pop_front()));
    repeat (3) @(negedge clk_sys);
    check(txEmpty, 1'b1);
    // Bypass: transmit FIFO drained by the subsystem, serial side silent
    acc(0, 1, `UFCB_SS_CTRL, 8'h80);
    // Control bit lands at the write edge, the status copy one edge later
    @(negedge clk_sys);
    check(bypassActive, 1'b1);
    pushTx(2);
    uSer.sendRx($random(seed), 3'h7);
    check(lineErr, 1'b0);
    check(uSer.txSeen.size(), 8'h00);
    while (txQ.size() > 0) begin
      acc(0, 0, `UFCB_SS_BYPASS, 8'h00);
      check(rdVal, 8'(txQ.pop_front()));
    end
    acc(0, 0, `UFCB_SS_BYPASS, 8'h00);
    check(rdVal, 8'h00);
    // Depth, trigger level and automatic ready-to-send for eight FIFO-control and extend settings
    foreach (modes[m]) begin
      fifo_control_reg = modes[m][7:0];
      extendPin = modes[m][8];
      deep = fifo_control_reg[5] && !extendPin;
      autoR = fifo_control_reg[4] && !extendPin;
      lvl = deep ? dLvl[fifo_control_reg[7:6]] : sLvl[fifo_control_reg[7:6]];
      thr = deep ? 56 : 14;
      lim = deep ? 64 : 16;
      acc(1, 1, `UFCB_H_FCR, fifo_control_reg | 8'h06);
      acc(1, 1, `UFCB_H_MCR, 8'h02);
      acc(0, 0, `UFCB_SS_FCR_RD, 8'h00);
      check(rdVal, {fifo_control_reg[7:6], !deep, !autoR, 3'h3, fifo_control_reg[0]});
      check(rtsN, 1'b0);
      for (k = 1; k <= (autoR ? thr : lim + 1); k++) begin
        d = $random(seed);
        acc(0, 1, `UFCB_SS_BYPASS, d);
        check(lineErr, k > lim);
        if (k <= lim) rxQ.push_back(d);
        repeat (2) @(negedge clk_sys);
        check(rxDataAvail, rxQ.size() >= lvl);
        check(rtsN, autoR && rxQ.size() >= thr);
      end
      while (rxQ.size() > 0) begin
        acc(1, 0, `UFCB_H_DATA, 8'h00);
        check(rdVal, 8'(rxQ.pop_front()));
      end
      acc(1, 1, `UFCB_H_MCR, 8'h02);
      repeat (2) @(negedge clk_sys);
      check(rtsN, 1'b0);
    end
    acc(0, 1, `UFCB_SS_CTRL, 8'h00);
    acc(0, 0, `UFCB_SS_BYPASS, 8'h00);
    check(rdVal, 8'h00);
    // Host drops ready-to-send by hand; pin follows one edge after the register
    acc(1, 1, `UFCB_H_MCR, 8'h00);
    acc(1, 0, `UFCB_H_STAT, 8'h00);
    check(rtsN, 1'b1);
    check(rdVal, 8'h60);
    acc(1, 0, `UFCB_H_MCR, 8'h00);
    check(rdVal, 8'h20);
    conclude();
  end
endmodule
